// ### src/mac_ctl_top.sv
/*
  MAC transmit and receive control/status block: register file behind a
  classic Wishbone slave, transmit sequencer with per-slot status, receive
  filter and a masked level interrupt.
  Assumes the transmit and receive datapaths report bytes, collisions and
  frame ends as single-cycle strobes on CLK, and carrier as a level.
*/
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`include "mac_ctl_map.svh"
// Operation
// - Transmit jabber timer runs at 2048 bytes unless jabber-off is set.
// - Without retry, abandon frame after sixteenth collision; with retry, keep sending.
// - Slot two frame gets no pad while its pad-off bit is set.
// - Slot two frame gets no FCS while its fcs-off bit is set.
// - Slot one frame skips pad with bit 2, FCS with bit 1.
// - Host writes send request; hardware clears it when the frame completes.
// - Each slot has its own status register, at 03H and 04H.
// - Status bit 7 marks a frame truncated after more than 2048 bytes.
// - Status bit 6 marks carrier lost during sending; invalid in internal loopback.
// - Status bit 5 marks no carrier at all; invalid in internal loopback.
// - Status bit 4 marks a collision after the first 64 bytes.
// - Status bit 3 marks any collision while sending.
// - Status bit 2 marks abort after 16 collisions; bits 1:0 read zero.
// - Receive watchdog at 2048 bytes unless watchdog-off is set.
// - Drop-oversize discards received frames longer than 1522 bytes.
// - Drop-bad-fcs discards frames ending with an FCS error.
// - Loopback field 01 loops frames inside the MAC.
// - Slot done flags set on completion; cleared by read or write one.
module mac_ctl_top
  import mac_ctl_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic        WB_WE_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  output logic             WB_ACK_O,
  output logic [31:0]      WB_DAT_O,
  output logic             IRQ,
  input  wire logic        TX_BYTE,
  input  wire logic        TX_END,
  input  wire logic        TX_CRS,
  input  wire logic        TX_COL,
  output logic             TX_SENDING,
  output logic             TX_SLOT,
  output logic             TX_PAD_ON,
  output logic             TX_FCS_ON,
  output logic             TX_CUT,
  output logic [1:0]       LOOPBACK_SEL,
  input  wire logic        RX_BYTE,
  input  wire logic        RX_END,
  input  wire logic        RX_FCS_BAD,
  input  wire logic        RX_MCAST,
  input  wire logic        RX_ADDR_MATCH,
  output logic             RX_ACCEPT,
  output logic             RX_DROP,
  output logic             RX_WD_CUT
);
  top_s  s_reg;
  top_s  s_next;
  reg_if r ();
  logic  rd_take;
  logic  fin;
  logic  abort;
  logic  jab;
  logic  carrier;
  logic  late;
  logic  [7:0] fstat;

  // True when a taken access writes the low byte of the given register.
  function automatic logic wr_hit(
    input logic       take,
    input logic       we,
    input logic       wen,
    input logic [5:0] idx,
    input logic [5:0] target
  );
    return take && we && wen && (idx == target);
  endfunction

  // Read value of a register; reserved bits and unmapped indices read zero.
  function automatic logic [7:0] rd_mux(
    input logic [5:0] idx,
    input top_s       st
  );
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      `IDX_NET_CTRL: v = {5'h00, st.loop, 1'b0};
      `IDX_NET_STAT: v = {4'h0, st.done2, st.done1, 2'h0};
      `IDX_TX_CTRL:  v = {1'b0, st.tctl};
      `IDX_TX_STAT1: v = {st.tstat1[7:2], 2'h0};
      `IDX_TX_STAT2: v = {st.tstat2[7:2], 2'h0};
      `IDX_RX_CTRL:  v = {1'b0, st.rctl};
      `IDX_INT_STAT: v = {4'h0, st.istat};
      `IDX_INT_MASK: v = {4'h0, st.imask};
      default:       v = 8'h00;
    endcase
    return v;
  endfunction

  // Bus front end; it registers the acknowledge and the read byte.
  wb_slave u_wb (
    .clk   (CLK),
    .rst_n (RST_N),
    .adr_i (WB_ADR_I),
    .dat_i (WB_DAT_I),
    .sel_i (WB_SEL_I),
    .we_i  (WB_WE_I),
    .cyc_i (WB_CYC_I),
    .stb_i (WB_STB_I),
    .ack_o (WB_ACK_O),
    .dat_o (WB_DAT_O),
    .r     (r)
  );

  // Receive filter steered by the receive control register.
  rx_filter u_rx (
    .clk        (CLK),
    .rst_n      (RST_N),
    .rctl       (s_reg.rctl),
    .rx_byte    (RX_BYTE),
    .rx_end     (RX_END),
    .fcs_bad    (RX_FCS_BAD),
    .mcast      (RX_MCAST),
    .addr_match (RX_ADDR_MATCH),
    .accept     (RX_ACCEPT),
    .drop       (RX_DROP),
    .wd_cut     (RX_WD_CUT)
  );

  // Read data is taken combinationally from the current register state.
  assign r.rdata = rd_mux(r.idx, s_reg);
  assign rd_take = r.take && !r.we;

  // Transmit sequencer: frame outcome for the cycle, before any register update.
  always_comb begin
    fstat   = s_reg.fstat;
    carrier = s_reg.seen_crs || TX_CRS;
    late    = TX_COL && (s_reg.bytes >= `COL_WINDOW_BYTES);
    abort   = TX_COL && !s_reg.tctl[`TC_RETRY] && (s_reg.cols >= `COL_LIMIT);
    jab     = !s_reg.tctl[`TC_JABBER_OFF] && (s_reg.bytes > `JABBER_BYTES);
    fin     = (s_reg.tst == TX_SEND) && (TX_END || abort || jab);
    if (s_reg.tst == TX_SEND) begin
      if (s_reg.seen_crs && !TX_CRS) begin
        fstat[`TS_CARRIER_LOST] = 1'b1;
      end
      if (TX_COL) begin
        fstat[`TS_COL] = 1'b1;
      end
      if (late) begin
        fstat[`TS_LATE_COL] = 1'b1;
      end
      if (abort) begin
        fstat[`TS_ABORT] = 1'b1;
      end
      if (jab) begin
        fstat[`TS_JABBER] = 1'b1;
      end
      if (fin && !carrier) begin
        fstat[`TS_NO_CARRIER] = 1'b1;
      end
      // Carrier flags carry no meaning when frames loop inside the MAC.
      if (fin && s_reg.loop == `LOOP_INTERNAL) begin
        fstat[`TS_CARRIER_LOST] = 1'b0;
        fstat[`TS_NO_CARRIER]   = 1'b0;
      end
    end
  end

  // Next state: software clears first, then hardware sets, so an event
  // landing in the same cycle as its clear is kept.
  always_comb begin
    s_next     = s_reg;
    s_next.cut = 1'b0;

    // Read-to-clear side effects of status registers.
    if (rd_take && r.idx == `IDX_NET_STAT) begin
      s_next.done1 = 1'b0;
      s_next.done2 = 1'b0;
    end
    if (rd_take && r.idx == `IDX_INT_STAT) begin
      s_next.istat = 4'h0;
    end

    // Write-one-to-clear of the slot done flags.
    if (wr_hit(r.take, r.we, r.wen, r.idx, `IDX_NET_STAT)) begin
      if (r.wdata[`NS_SLOT_ONE]) begin
        s_next.done1 = 1'b0;
      end
      if (r.wdata[`NS_SLOT_TWO]) begin
        s_next.done2 = 1'b0;
      end
    end

    // A completed frame drops the send request; a host write below wins.
    if (fin) begin
      s_next.tctl[`TC_SEND] = 1'b0;
    end

    // Plain control writes.
    if (wr_hit(r.take, r.we, r.wen, r.idx, `IDX_NET_CTRL)) begin
      s_next.loop = r.wdata[`NC_LOOP_LSB+:2];
    end
    if (wr_hit(r.take, r.we, r.wen, r.idx, `IDX_TX_CTRL)) begin
      s_next.tctl = r.wdata[6:0];
    end
    if (wr_hit(r.take, r.we, r.wen, r.idx, `IDX_RX_CTRL)) begin
      s_next.rctl = r.wdata[6:0];
    end
    if (wr_hit(r.take, r.we, r.wen, r.idx, `IDX_INT_MASK)) begin
      s_next.imask = r.wdata[3:0];
    end

    // Transmit state machine.
    unique case (s_reg.tst)
      TX_IDLE: begin
        if (s_reg.tctl[`TC_SEND]) begin
          s_next.tst       = TX_SEND;
          s_next.slot      = s_reg.next_slot;
          s_next.next_slot = !s_reg.next_slot;
          s_next.bytes     = 12'h000;
          s_next.cols      = 5'h00;
          s_next.seen_crs  = 1'b0;
          s_next.fstat     = 8'h00;
          // Pad and FCS insertion are fixed per slot for the whole frame.
          if (s_reg.next_slot) begin
            s_next.pad_on = !s_reg.tctl[`TC_PAD_OFF2];
            s_next.fcs_on = !s_reg.tctl[`TC_FCS_OFF2];
          end else begin
            s_next.pad_on = !s_reg.tctl[`TC_PAD_OFF1];
            s_next.fcs_on = !s_reg.tctl[`TC_FCS_OFF1];
          end
        end
      end
      TX_SEND: begin
        s_next.fstat    = fstat;
        s_next.seen_crs = carrier;
        if (TX_BYTE && s_reg.bytes != `BYTE_SAT) begin
          s_next.bytes = s_reg.bytes + 12'h001;
        end
        // Collision count saturates so retry mode can run on forever.
        if (TX_COL && s_reg.cols != `COL_SAT) begin
          s_next.cols = s_reg.cols + 5'h01;
        end
        if (fin) begin
          s_next.tst = TX_IDLE;
          s_next.cut = abort || jab;
          if (s_reg.slot) begin
            s_next.tstat2 = fstat;
            s_next.done2  = 1'b1;
          end else begin
            s_next.tstat1 = fstat;
            s_next.done1  = 1'b1;
          end
        end
      end
    endcase

    // Sticky interrupt events, set after any clear of this cycle.
    if (fin && !s_reg.slot) begin
      s_next.istat[`IS_SLOT_ONE] = 1'b1;
    end
    if (fin && s_reg.slot) begin
      s_next.istat[`IS_SLOT_TWO] = 1'b1;
    end
    if (RX_ACCEPT) begin
      s_next.istat[`IS_RX_ACCEPT] = 1'b1;
    end
    if (RX_DROP) begin
      s_next.istat[`IS_RX_DROP] = 1'b1;
    end
    s_next.irq = |(s_next.istat & s_next.imask);
  end

  // State register; every control field resets to zero.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register.
  assign IRQ          = s_reg.irq;
  assign TX_SENDING   = (s_reg.tst == TX_SEND);
  assign TX_SLOT      = s_reg.slot;
  assign TX_PAD_ON    = s_reg.pad_on;
  assign TX_FCS_ON    = s_reg.fcs_on;
  assign TX_CUT       = s_reg.cut;
  assign LOOPBACK_SEL = s_reg.loop;
endmodule

// ### src/mac_ctl_map.svh
/*
  Register indices, field positions, reset values and byte limits of the
  MAC transmit/receive control block.
  Assumes it is included by bare name from every design file that needs it.
*/
`ifndef MAC_CTL_MAP_SVH
`define MAC_CTL_MAP_SVH
// Register indices; the bus byte address is four times the index.
`define IDX_NET_CTRL     6'h00
`define IDX_NET_STAT     6'h01
`define IDX_TX_CTRL      6'h02
`define IDX_TX_STAT1     6'h03
`define IDX_TX_STAT2     6'h04
`define IDX_RX_CTRL      6'h05
`define IDX_INT_STAT     6'h30
`define IDX_INT_MASK     6'h31
// Transmit control fields.
`define TC_JABBER_OFF    6
`define TC_RETRY         5
`define TC_PAD_OFF2      4
`define TC_FCS_OFF2      3
`define TC_PAD_OFF1      2
`define TC_FCS_OFF1      1
`define TC_SEND          0
// Transmit status fields, same layout for both slots.
`define TS_JABBER        7
`define TS_CARRIER_LOST  6
`define TS_NO_CARRIER    5
`define TS_LATE_COL      4
`define TS_COL           3
`define TS_ABORT         2
// Receive control fields.
`define RC_WD_OFF        6
`define RC_DROP_LONG     5
`define RC_DROP_FCS      4
`define RC_ALL_MCAST     3
`define RC_RUNT          2
`define RC_ANY_DEST      1
`define RC_ON            0
// Network control loopback field (bits 2:1) and network status flags.
`define NC_LOOP_LSB      1
`define LOOP_INTERNAL    2'h1
`define NS_SLOT_ONE      2
`define NS_SLOT_TWO      3
// Interrupt status and mask bits.
`define IS_SLOT_ONE      0
`define IS_SLOT_TWO      1
`define IS_RX_ACCEPT     2
`define IS_RX_DROP       3
// Reset value of every register.
`define REG_RESET        8'h00
// Byte and collision limits.
`define JABBER_BYTES     12'h800
`define WATCHDOG_BYTES   12'h800
`define COL_WINDOW_BYTES 12'h040
`define LONG_BYTES       12'h5f2
`define RUNT_BYTES       12'h040
`define COL_LIMIT        5'h0f
`define COL_SAT          5'h10
`define BYTE_SAT         12'hfff
`endif

// ### src/mac_ctl_pkg.sv
/*
  Types shared by the MAC control block: transmit states and the packed
  state records of each module.
  Assumes nothing of its surroundings.
*/
package mac_ctl_pkg;
  typedef enum logic {TX_IDLE, TX_SEND} tx_state_e;

  typedef struct packed {
    logic [1:0]  loop;
    logic [6:0]  tctl;
    logic [7:0]  tstat1;
    logic [7:0]  tstat2;
    logic [6:0]  rctl;
    logic        done1;
    logic        done2;
    logic [3:0]  istat;
    logic [3:0]  imask;
    logic        irq;
    tx_state_e   tst;
    logic        slot;
    logic        next_slot;
    logic [11:0] bytes;
    logic [4:0]  cols;
    logic        seen_crs;
    logic [7:0]  fstat;
    logic        pad_on;
    logic        fcs_on;
    logic        cut;
  } top_s;

  typedef struct packed {
    logic [11:0] bytes;
    logic        cut;
    logic        wd;
    logic        acc;
    logic        drop;
  } rx_s;

  typedef struct packed {
    logic       ack;
    logic [7:0] rdat;
  } wb_s;
endpackage

// ### src/reg_if.sv
/*
  Carrier between the bus slave and the register file: one taken access
  per strobe, with the read byte returned in the same cycle.
  Assumes a single clock shared by both ends.
*/
`timescale 1ns/1ps
interface reg_if;
  logic       take;
  logic       we;
  logic       wen;
  logic [5:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport bus  (output take, we, wen, idx, wdata, input rdata);
  modport regs (input take, we, wen, idx, wdata, output rdata);
endinterface

// ### src/wb_slave.sv
/*
  Classic Wishbone slave front end: takes at most one access every second cycle and
  registers the acknowledge and the read byte.
  Assumes a master that holds its request until it sees the acknowledge.
*/
`timescale 1ns/1ps
module wb_slave
  import mac_ctl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  output logic [31:0]      dat_o,
  reg_if.bus               r
);
  wb_s s_reg;
  wb_s s_next;

  // An access is taken once; the acknowledge blocks a second take.
  assign r.take  = cyc_i && stb_i && !s_reg.ack;
  assign r.we    = we_i;
  assign r.wen   = sel_i[0];
  assign r.idx   = adr_i[7:2];
  assign r.wdata = dat_i[7:0];

  // Acknowledge and read data follow the take by one cycle.
  always_comb begin
    s_next      = s_reg;
    s_next.ack  = r.take;
    if (r.take) begin
      s_next.rdat = we_i ? 8'h00 : r.rdata;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ack_o = s_reg.ack;
  assign dat_o = {24'h000000, s_reg.rdat};
endmodule

// ### src/rx_filter.sv
/*
  Receive frame counter, watchdog and acceptance decision.
  Assumes one byte strobe per received byte and a frame end strobe in a
  later cycle than the last byte strobe.
*/
`timescale 1ns/1ps
`include "mac_ctl_map.svh"
module rx_filter
  import mac_ctl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [6:0] rctl,
  input  wire logic       rx_byte,
  input  wire logic       rx_end,
  input  wire logic       fcs_bad,
  input  wire logic       mcast,
  input  wire logic       addr_match,
  output logic            accept,
  output logic            drop,
  output logic            wd_cut
);
  rx_s  s_reg;
  rx_s  s_next;
  logic keep;

  // Count bytes, run the watchdog and judge each frame at its end.
  always_comb begin
    s_next      = s_reg;
    s_next.acc  = 1'b0;
    s_next.drop = 1'b0;
    s_next.wd   = 1'b0;
    keep        = 1'b0;
    if (rx_byte && rctl[`RC_ON] && s_reg.bytes != `BYTE_SAT) begin
      s_next.bytes = s_reg.bytes + 12'h001;
    end
    if (!rctl[`RC_WD_OFF] && !s_reg.cut && s_reg.bytes > `WATCHDOG_BYTES) begin
      s_next.cut = 1'b1;
      s_next.wd  = 1'b1;
    end
    if (rx_end) begin
      keep = rctl[`RC_ON] && !s_reg.cut
        && !(rctl[`RC_DROP_LONG] && s_reg.bytes > `LONG_BYTES)
        && !(rctl[`RC_DROP_FCS] && fcs_bad)
        && (rctl[`RC_RUNT] || s_reg.bytes >= `RUNT_BYTES)
        && (rctl[`RC_ANY_DEST] || addr_match || (rctl[`RC_ALL_MCAST] && mcast));
      s_next.acc   = keep;
      s_next.drop  = rctl[`RC_ON] && !keep;
      s_next.bytes = 12'h000;
      s_next.cut   = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign accept = s_reg.acc;
  assign drop   = s_reg.drop;
  assign wd_cut = s_reg.wd;
endmodule

// ### testbench/mac_ctl_properties.sv
/*
  Concurrent checks on the bus answer and the transmit and receive strobes.
  Assumes it is bound to mac_ctl_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module mac_ctl_properties (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_ACK_O,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        TX_SENDING,
  input wire logic        TX_SLOT,
  input wire logic        TX_CUT,
  input wire logic        RX_END,
  input wire logic        RX_ACCEPT,
  input wire logic        RX_DROP
);
  logic prev_slot;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Remembers the slot of the last frame; reset makes slot one come first.
  always_ff @(posedge CLK) begin
    if (!RST_N) prev_slot <= 1'b1;
    else if (TX_SENDING) prev_slot <= TX_SLOT;
  end
  // Bus answers: one cycle after the taking edge, never unasked.
  ack_resp_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not answered");
  ack_once_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  ack_idle_a: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
    else $error("ack without request");
  read_high_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
    else $error("upper read bits set");
  // An abort or jabber cut ends the frame in progress, and only for one cycle.
  cut_ends_a: assert property (TX_CUT |-> !TX_SENDING && $past(TX_SENDING))
    else $error("cut without frame end");
  cut_once_a: assert property (TX_CUT |=> !TX_CUT) else $error("cut too long");
  slot_hold_a: assert property (TX_SENDING && $past(TX_SENDING) |-> $stable(TX_SLOT))
    else $error("slot changed in frame");
  slot_alt_a: assert property ($rose(TX_SENDING) |-> TX_SLOT != prev_slot)
    else $error("slots not alternating");
  rx_excl_a: assert property (!(RX_ACCEPT && RX_DROP)) else $error("accept and drop");
  rx_cause_a: assert property (RX_ACCEPT || RX_DROP |-> $past(RX_END))
    else $error("decision without frame end");
  cover property ($rose(TX_SENDING) && TX_SLOT);
  cover property (TX_CUT);
  cover property (RX_DROP);
  cover property (RX_ACCEPT);
endmodule
bind mac_ctl_top mac_ctl_properties u_prop (.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O), .TX_SENDING(TX_SENDING),
  .TX_SLOT(TX_SLOT), .TX_CUT(TX_CUT), .RX_END(RX_END), .RX_ACCEPT(RX_ACCEPT),
  .RX_DROP(RX_DROP));

// ### testbench/mac_host_model.sv
/*
  Host processor model: a classic Wishbone master doing one access a call.
  Assumes a slave that answers with ack; a bounded wait reports failure.
*/
`timescale 1ns/1ps
module mac_host_model (
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic [31:0] dat_o,
  output logic [7:0]       adr,
  output logic [31:0]      dat_i,
  output logic [3:0]       sel,
  output logic             we,
  output logic             cyc,
  output logic             stb
);
  initial {adr, dat_i, sel, we, cyc, stb} = '0;
  // Raises the request after an edge and holds it until ack is sampled high.
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic ok);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, sel} <= {2'b11, w, a, 4'h1};
    dat_i <= {~d, ~d, ~d, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    ok = (ack === 1'b1);
    {cyc, stb, sel} <= '0;
    adr <= ~a;
    dat_i <= ~dat_i;
  endtask
endmodule

// ### testbench/test_mac_txrx_control_status.sv
/*
  Self-checking bench of mac_ctl_top: registers, transmit slots, receive
  filter and interrupt. Assumes mac_host_model and the bound checker.
*/
`timescale 1ns/1ps
module test_mac_txrx_control_status;
  import mac_ctl_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, rx_end_d = 1'b0;
  logic        tx_byte = 0, tx_end = 0, tx_crs = 0, tx_col = 0;
  logic        rx_byte = 0, rx_end = 0, fcs_bad = 0, mcast = 0, match = 0;
  logic        ack, irq, sending, slot, pad_on, fcs_on, cut, acc, drp, wd, we, cyc, stb;
  logic [1:0]  loop_sel;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [31:0] dat_o, dat_i, rnd = 32'h00010c03;
  logic [31:0] exp_q[$], rx_q[$];
  int          n_mismatch = 0, n_compared = 0, n_cut = 0, n_wd = 0, c0, s;
  localparam logic [7:0] tc [7] = '{8'h05, 8'h09, 8'h01, 8'h01, 8'h21, 8'h01, 8'h41};
  localparam logic [7:0] st [7] = '{8'h08, 8'h38, 8'h00, 8'h0c, 8'h08, 8'h80, 8'h00};
  localparam int nb [7] = '{10, 70, 5, 0, 0, 2049, 2049};
  localparam int nc [7] = '{1, 1, 0, 16, 17, 0, 0};
  localparam logic [7:0] rc [13] = '{1, 1, 3, 9, 8'h11, 1, 1, 5, 8'h21, 1, 0, 8'h43, 3};
  localparam int rn [13] = '{70, 70, 70, 70, 70, 70, 10, 10, 1523, 1523, 70, 2049, 2049};
  // Receive levels and decision: {match, mcast, fcs_bad, accept, drop}.
  localparam logic [4:0] rf [13] = '{5'h12, 5'h01, 5'h02, 5'h0a, 5'h15, 5'h16, 5'h11,
                                     5'h12, 5'h11, 5'h12, 5'h10, 5'h12, 5'h10};
  always #20 clk = ~clk;
  mac_ctl_top u_dut (.CLK(clk), .RST_N(rst_n), .WB_ADR_I(adr), .WB_DAT_I(dat_i),
    .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack),
    .WB_DAT_O(dat_o), .IRQ(irq), .TX_BYTE(tx_byte), .TX_END(tx_end), .TX_CRS(tx_crs),
    .TX_COL(tx_col), .TX_SENDING(sending), .TX_SLOT(slot), .TX_PAD_ON(pad_on),
    .TX_FCS_ON(fcs_on), .TX_CUT(cut), .LOOPBACK_SEL(loop_sel), .RX_BYTE(rx_byte),
    .RX_END(rx_end), .RX_FCS_BAD(fcs_bad), .RX_MCAST(mcast), .RX_ADDR_MATCH(match),
    .RX_ACCEPT(acc), .RX_DROP(drp), .RX_WD_CUT(wd));
  mac_host_model u_host (.clk(clk), .ack(ack), .dat_o(dat_o), .adr(adr), .dat_i(dat_i),
    .sel(sel), .we(we), .cyc(cyc), .stb(stb));
  task automatic close_out();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Next value of the stimulus shift register.
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("Error at %0t: expected %h got %h", $time, e, g);
      n_mismatch++;
    end
  endtask
  // A read notes its expected byte in d; a write stores d.
  task automatic reg_acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic ok;
    if (!w) exp_q.push_back({24'h0, d});
    u_host.access(w, a, d, ok);
    if (!ok) begin
      n_mismatch++;
      close_out();
    end
  endtask
  task automatic wait_tx(input logic lv);
    int n;
    n = 0;
    while (sending !== lv && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (sending !== lv) begin
      n_mismatch++;
      close_out();
    end
  endtask
  // Sends n byte strobes, one every second cycle, on the transmit or receive side.
  task automatic bytes(input int n, input logic rx);
    repeat (n) begin
      if (rx) rx_byte <= 1'b1;
      else tx_byte <= 1'b1;
      @(posedge clk);
      {rx_byte, tx_byte} <= 2'b00;
      @(posedge clk);
    end
  endtask
  // Compares read bytes and receive decisions against the oldest notes.
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) chk(exp_q.pop_front(), dat_o);
    if (rx_end_d) chk(rx_q.pop_front(), {30'h0, acc, drp});
    rx_end_d <= rx_end;
    n_cut += (cut === 1'b1);
    n_wd += (wd === 1'b1);
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    foreach (tc[i]) reg_acc(1'b0, {i[5:0] + 6'h2, 2'b00}, 8'h00);
    reg_acc(1'b0, 8'h3c, 8'h00);
    repeat (4) begin
      rnd = lfsr(rnd);
      reg_acc(1'b1, 8'h14, rnd[7:0]);
      reg_acc(1'b0, 8'h14, rnd[7:0] & 8'h7f);
      reg_acc(1'b1, 8'h08, rnd[15:8] & 8'hfe);
      reg_acc(1'b0, 8'h08, rnd[15:8] & 8'h7e);
    end
    reg_acc(1'b1, 8'hc4, 8'h02);
    // Frames alternate slots one and two.
    foreach (tc[i]) begin
      s = i % 2;
      if (i == 2) reg_acc(1'b1, 8'h00, 8'h02);
      if (i == 2) chk(2'h1, loop_sel);
      reg_acc(1'b1, 8'h08, tc[i]);
      wait_tx(1'b1);
      chk(s, slot);
      chk(!tc[i][s ? 4 : 2], pad_on);
      chk(!tc[i][s ? 3 : 1], fcs_on);
      c0 = n_cut;
      tx_crs <= (i != 1 && i != 2);
      bytes(nb[i], 1'b0);
      repeat (nc[i]) begin
        tx_col <= 1'b1;
        @(posedge clk);
      end
      tx_col <= 1'b0;
      if (!(st[i][7] || st[i][2])) begin
        chk(1'b1, sending);
        tx_end <= 1'b1;
        @(posedge clk);
        tx_end <= 1'b0;
      end
      wait_tx(1'b0);
      tx_crs <= 1'b0;
      @(posedge clk);
      chk(st[i][7] || st[i][2], n_cut - c0);
      if (i == 2) reg_acc(1'b1, 8'h00, 8'h00);
      reg_acc(1'b0, s ? 8'h10 : 8'h0c, st[i]);
      reg_acc(1'b0, s ? 8'h0c : 8'h10, i > 0 ? st[i - 1] : 8'h00);
      reg_acc(1'b0, 8'h08, tc[i] & 8'h7e);
      chk(i > 0, irq);
    end
    reg_acc(1'b1, 8'h0c, 8'hff);
    reg_acc(1'b0, 8'h0c, 8'h00);
    reg_acc(1'b1, 8'h04, 8'h04);
    reg_acc(1'b0, 8'h04, 8'h08);
    reg_acc(1'b0, 8'h04, 8'h00);
    reg_acc(1'b0, 8'hc0, 8'h03);
    chk(1'b0, irq);
    // Receive frames: control, length and levels against the decision.
    foreach (rc[i]) begin
      reg_acc(1'b1, 8'h14, rc[i]);
      c0 = n_wd;
      {match, mcast, fcs_bad} <= rf[i][4:2];
      bytes(rn[i], 1'b1);
      if (i < 12) rx_q.push_back({30'h0, rf[i][1:0]});
      if (i < 12) rx_end <= 1'b1;
      @(posedge clk);
      rx_end <= 1'b0;
      repeat (3) @(posedge clk);
      chk(i == 12, n_wd - c0);
    end
    close_out();
  end
endmodule
